// *** test/testbench.sv ***
// Testbench for the sixteen-bit timer: register bus master, counting, overflow, pin control.
// Assumes the clock model drives the counter pin in step with aclk.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tsx_pkg::*;
	// ==========================================================
	// Signals
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, got, prev, rnd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        external_clock_pin, special_event_trigger, cpu_sleep, osc_output_pin, osc_input_pin;
	logic        osc_output_pin_oe_n, osc_input_pin_oe_n, osc_inverter_on, irq, wake, slp;
	int          n_errors, checked, cycles, n;
	tsx_timer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .external_clock_pin, .special_event_trigger, .cpu_sleep, .osc_output_pin,
		.osc_input_pin, .osc_output_pin_oe_n, .osc_input_pin_oe_n, .osc_inverter_on, .irq, .wake);
	tsx_ext_clk_model u_ext (.aclk, .pin(external_clock_pin));
	// Clock and hang guard; the run needs under two thousand cycles
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	// ==========================================================
	// Compare, bus and closing tasks
	task automatic chk32(input logic [31:0] exp, input logic [31:0] act);
		checked++;
		if (act !== exp) begin
			n_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, act);
		end
	endtask : chk32
	task automatic chk_resp(input logic [1:0] exp, input logic [1:0] act);
		checked++;
		if (act !== exp) begin
			n_errors++;
			$display("ERROR t=%0t resp exp=%h got=%h", $time, exp, act);
		end
	endtask : chk_resp
	// Address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk_resp(er, s_axi_bresp);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		chk_resp(er, s_axi_rresp);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic trig;
		@(posedge aclk);
		special_event_trigger <= 1'b1;
		@(posedge aclk);
		special_event_trigger <= 1'b0;
	endtask : trig
	task automatic finish_test;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	// Expected low count after n pin edges: prescale divides, sleep stops the synchronised path
	function automatic logic [31:0] exp_count(input int n, input logic [1:0] ps, input logic byp,
		input logic sleep);
		return (byp || !sleep) ? 32'(n >> ps) : 32'h0;
	endfunction : exp_count
	// ==========================================================
	// Main sequence
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, special_event_trigger, cpu_sleep} = '0;
		{osc_output_pin, osc_input_pin, s_axi_wstrb} = 6'h3f;
		void'($urandom(32'h7dc0));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(TSX_ADDR_CONTROL + 8'(4 * i), TSX_RESP_OKAY, got);
			chk32(32'h0, got);
		end
		rd(TSX_ADDR_PIN_CTRL, TSX_RESP_OKAY, got);
		chk32(32'hc0, got);
		// Byte halves read back, then the high byte reads zero after the trigger
		rnd = $urandom;
		wr(TSX_ADDR_COUNT_LO, {24'h0, rnd[7:0]}, TSX_RESP_OKAY);
		wr(TSX_ADDR_COUNT_HI, {24'h0, rnd[15:8]}, TSX_RESP_OKAY);
		rd(TSX_ADDR_COUNT_LO, TSX_RESP_OKAY, got);
		chk32({24'h0, rnd[7:0]}, got);
		rd(TSX_ADDR_COUNT_HI, TSX_RESP_OKAY, got);
		chk32({24'h0, rnd[15:8]}, got);
		trig();
		rd(TSX_ADDR_COUNT_HI, TSX_RESP_OKAY, got);
		chk32(32'h0, got);
		// Counter mode: every ratio, both paths, sleep at random
		for (int i = 0; i < 8; i++) begin
			n = 8 + $urandom % 32;
			slp = 1'($urandom);
			wr(TSX_ADDR_CONTROL, {26'h0, 2'(i), 1'b0, i[2], 2'b11}, TSX_RESP_OKAY);
			trig();
			cpu_sleep <= slp;
			u_ext.pulses(n, 1 + i % 3);
			repeat (4) @(posedge aclk);
			rd(TSX_ADDR_COUNT_LO, TSX_RESP_OKAY, got);
			chk32(exp_count(n, i[1:0], i[2], slp), got);
			cpu_sleep <= 1'b0;
		end
		// Wrap during sleep on the unsynchronised path
		wr(TSX_ADDR_COUNT_LO, 32'hff, TSX_RESP_OKAY);
		wr(TSX_ADDR_COUNT_HI, 32'hff, TSX_RESP_OKAY);
		wr(TSX_ADDR_IRQ_EN, 32'h1, TSX_RESP_OKAY);
		cpu_sleep <= 1'b1;
		wr(TSX_ADDR_CONTROL, 32'h7, TSX_RESP_OKAY);
		u_ext.pulses(1, 2);
		repeat (4) @(posedge aclk);
		chk32(32'h3, {30'h0, irq, wake});
		rd(TSX_ADDR_COUNT_HI, TSX_RESP_OKAY, got);
		chk32(32'h0, got);
		cpu_sleep <= 1'b0;
		wr(TSX_ADDR_IRQ_EN, 32'h0, TSX_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk32(32'h0, {31'h0, irq});
		rd(TSX_ADDR_IRQ_FLAG, TSX_RESP_OKAY, got);
		chk32(32'h1, got);
		wr(TSX_ADDR_IRQ_FLAG, 32'h1, TSX_RESP_OKAY);
		rd(TSX_ADDR_IRQ_FLAG, TSX_RESP_OKAY, got);
		chk32(32'h0, got);
		// Timer mode runs, stop holds the value
		wr(TSX_ADDR_CONTROL, 32'h1, TSX_RESP_OKAY);
		rd(TSX_ADDR_COUNT_LO, TSX_RESP_OKAY, prev);
		rd(TSX_ADDR_COUNT_LO, TSX_RESP_OKAY, got);
		// Back-to-back reads sample the count four clocks apart
		chk32({24'h0, 8'(prev[7:0] + 8'h04)}, got);
		wr(TSX_ADDR_CONTROL, 32'h0, TSX_RESP_OKAY);
		rd(TSX_ADDR_COUNT_LO, TSX_RESP_OKAY, prev);
		repeat (5) @(posedge aclk);
		rd(TSX_ADDR_COUNT_LO, TSX_RESP_OKAY, got);
		chk32(prev, got);
		// Oscillator takes the pins; unimplemented control bits read zero
		wr(TSX_ADDR_PIN_CTRL, 32'h0, TSX_RESP_OKAY);
		for (int i = 0; i < 2; i++) begin
			wr(TSX_ADDR_CONTROL, 32'hc0 | 32'(i << 3), TSX_RESP_OKAY);
			repeat (2) @(posedge aclk);
			chk32({29'h0, {3{i[0]}}}, {29'h0, osc_inverter_on, osc_output_pin_oe_n, osc_input_pin_oe_n});
			rd(TSX_ADDR_PIN_READ, TSX_RESP_OKAY, got);
			chk32(i ? 32'h0 : 32'hc0, got);
			rd(TSX_ADDR_CONTROL, TSX_RESP_OKAY, got);
			chk32(32'(i << 3), got);
		end
		wr(8'h40, 32'h1, TSX_RESP_SLVERR);
		rd(8'h44, TSX_RESP_SLVERR, got);
		finish_test();
	end
endmodule : testbench
`default_nettype wire

// *** test/tsx_ext_clk_model.sv ***
// External clock source for the counter pin: bursts of rising edges.
// Assumes the timer samples the pin on aclk.
`timescale 1ns/1ps
`default_nettype none
module tsx_ext_clk_model (
	// Clock
	input  wire logic aclk,
	// Pin
	output logic      pin
);
	// ==========================================================
	// Burst of n edges; slow sources use a larger half period. Idle low between bursts.
	initial pin = 1'b0;
	task automatic pulses(input int n, input int half);
		repeat (n) begin
			repeat (half) @(posedge aclk);
			pin <= 1'b1;
			repeat (half) @(posedge aclk);
			pin <= 1'b0;
		end
	endtask : pulses
endmodule : tsx_ext_clk_model
`default_nettype wire

// *** test/tsx_timer_assertions.sv ***
// Checker for the sixteen-bit timer, watching only the top ports.
// Assumes one clock domain and aresetn synchronous, active low.
`timescale 1ns/1ps
`default_nettype none
module tsx_timer_assertions (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Timer side
	input wire logic        cpu_sleep,
	input wire logic        osc_output_pin_oe_n,
	input wire logic        osc_input_pin_oe_n,
	input wire logic        osc_inverter_on,
	input wire logic        irq,
	input wire logic        wake
);
	import tsx_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// Helper: whether the last taken write address hit a writable register
	logic aw_mapped;
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready)
			aw_mapped <= s_axi_awaddr >= TSX_ADDR_CONTROL && s_axi_awaddr <= TSX_ADDR_PIN_CTRL
				&& s_axi_awaddr[1:0] == 2'h0;
	end
	// ==========================================================
	// Handshake steps
	sequence s_read_answer;
		##1 s_axi_arready ##1 s_axi_rvalid;
	endsequence
	sequence s_write_answer;
		##[1:2] s_axi_bvalid;
	endsequence
	a_read_latency: assert property ($rose(s_axi_arvalid) |-> s_read_answer)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> s_write_answer)
		else $error("write answer late");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	a_write_resp_code: assert property ($rose(s_axi_bvalid) |->
		s_axi_bresp == (aw_mapped ? TSX_RESP_OKAY : TSX_RESP_SLVERR)) else $error("wrong write response");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_wake_needs_irq: assert property (wake |-> irq && $past(cpu_sleep))
		else $error("wake without pending interrupt in sleep");
	a_osc_pins_input: assert property (osc_inverter_on |->
		osc_output_pin_oe_n && osc_input_pin_oe_n) else $error("pin driven while oscillator on");
	a_irq_fall_cause: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("interrupt dropped without register write");
endmodule : tsx_timer_assertions
bind tsx_timer tsx_timer_assertions u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .cpu_sleep, .osc_output_pin_oe_n, .osc_input_pin_oe_n, .osc_inverter_on, .irq, .wake);
`default_nettype wire

// *** verilog/tsx_pkg.sv ***
// Package for the sixteen-bit timer: register map, field positions, reset values.
// Assumes an AXI4-Lite slave with 32-bit data, one register per aligned word.
`default_nettype none
package tsx_pkg;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] TSX_ADDR_CONTROL   = 8'h10; // timer_control
	localparam logic [7:0] TSX_ADDR_COUNT_LO  = 8'h14; // count_low_byte
	localparam logic [7:0] TSX_ADDR_COUNT_HI  = 8'h18; // count_high_byte
	localparam logic [7:0] TSX_ADDR_IRQ_FLAG  = 8'h1c; // peripheral_flag_register
	localparam logic [7:0] TSX_ADDR_IRQ_EN    = 8'h20; // peripheral_enable_register
	localparam logic [7:0] TSX_ADDR_PIN_CTRL  = 8'h24; // port_direction_bits
	localparam logic [7:0] TSX_ADDR_PIN_READ  = 8'h28; // pin levels as seen by software

	// ==========================================================
	// Control, flag and pin control register field positions
	localparam int TSX_BIT_RUN      = 0;
	localparam int TSX_BIT_CLK_SEL  = 1;
	localparam int TSX_BIT_SYNC_BYP = 2;
	localparam int TSX_BIT_OSC_EN   = 3;
	localparam int TSX_BIT_PS_LO    = 4;
	localparam int TSX_BIT_FLAG     = 0;
	localparam int TSX_BIT_DIR_LO   = 6;

	// ==========================================================
	// Reset values and count maximum
	localparam logic [5:0]  TSX_RST_CONTROL = 6'h00;
	localparam logic [15:0] TSX_RST_COUNT   = 16'h0000;
	localparam logic [1:0]  TSX_RST_DIR     = 2'h3;
	localparam logic [15:0] TSX_COUNT_MAX   = 16'hffff;

	// ==========================================================
	// Prescale ratio selections
	typedef enum logic [1:0] {
		TSX_PS_1 = 2'b00,
		TSX_PS_2 = 2'b01,
		TSX_PS_4 = 2'b10,
		TSX_PS_8 = 2'b11
	} tsx_ps_e;

	// AXI response codes
	localparam logic [1:0] TSX_RESP_OKAY   = 2'b00;
	localparam logic [1:0] TSX_RESP_SLVERR = 2'b10;

endpackage : tsx_pkg
`default_nettype wire

// *** verilog/tsx_prescaler.sv ***
// Prescaler for the sixteen-bit timer: passes one tick in every 1, 2, 4 or 8 events.
// Assumes events arrive as one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tsx_prescaler (
	// Clock and reset
	input  wire logic            aclk,
	input  wire logic            aresetn,
	// Control
	input  wire tsx_pkg::tsx_ps_e ratio,
	input  wire logic            clear,
	// Events in, ticks out
	input  wire logic            event_in,
	output logic                 tick
);
	import tsx_pkg::*;

	logic [2:0] div_count;
	logic [2:0] next_div_count;
	logic [2:0] last_count;
	logic       wrap;

	// ==========================================================
	// Terminal count per ratio
	assign last_count = (ratio == TSX_PS_8) ? 3'h7 :
	                    (ratio == TSX_PS_4) ? 3'h3 :
	                    (ratio == TSX_PS_2) ? 3'h1 : 3'h0;
	assign wrap           = event_in && (div_count >= last_count);
	assign next_div_count = wrap ? 3'h0 : (div_count + 3'h1);

	// Divider state; cleared with the counter so a fresh ratio starts clean
	always_ff @(posedge aclk) begin
		if (!aresetn || clear) begin
			div_count <= 3'h0;
		end else if (event_in) begin
			div_count <= next_div_count;
		end
	end

	// Combinational tick lets the counter advance on the same edge as the event
	assign tick = wrap;

endmodule : tsx_prescaler
`default_nettype wire

// *** verilog/tsx_timer.sv ***
// Sixteen-bit timer/counter with prescaler, overflow interrupt and AXI4-Lite registers.
// Assumes the external clock pin is synchronous to aclk, as are all other inputs.
// Overview of operation
// - Counter is two readable writable byte halves
// - Counts up, wraps from ffff to 0000
// - Wrap sets sticky overflow flag bit 0
// - Interrupt raised only while enable bit set
// - Timer, sync counter and async counter modes
// - Timer mode advances once per clock
// - Counter mode advances on external rising edges
// - Counts only while run bit set
// - Trigger input clears the counter
// - Oscillator enable forces pins input, read zero
// - Prescale field picks 1:1, 1:2, 1:4, 1:8
// - Sync bypass picks unsynchronised external path
// - Clock select: external pin or internal clock
// - Async counter runs in sleep, wakes
// - Oscillator runs only while enable set
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tsx_timer (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Timer event inputs
	input  wire logic        external_clock_pin,
	input  wire logic        special_event_trigger,
	input  wire logic        cpu_sleep,
	// Oscillator pins, as level inputs and controls
	input  wire logic        osc_output_pin,
	input  wire logic        osc_input_pin,
	output logic             osc_output_pin_oe_n,
	output logic             osc_input_pin_oe_n,
	output logic             osc_inverter_on,
	// Interrupt and wake
	output logic             irq,
	output logic             wake
);
	import tsx_pkg::*;

	// ==========================================================
	// State
	logic [5:0]  timer_control;
	logic [15:0] count;
	logic        overflow_flag;
	logic        overflow_irq_enable;
	logic [1:0]  port_direction_bits;
	logic        ext_sync1;
	logic        ext_sync2;
	logic        ext_prev;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// ==========================================================
	// Control fields
	wire         run_control          = timer_control[TSX_BIT_RUN];
	wire         clock_source_select  = timer_control[TSX_BIT_CLK_SEL];
	wire         external_sync_bypass = timer_control[TSX_BIT_SYNC_BYP];
	wire         low_power_osc_enable = timer_control[TSX_BIT_OSC_EN];
	wire tsx_ps_e prescale_select     = tsx_ps_e'(timer_control[TSX_BIT_PS_LO +: 2]);

	// ==========================================================
	// Event selection
	// The bypass path skips the two-stage synchroniser and so sees edges two cycles early.
	wire ext_level  = external_sync_bypass ? external_clock_pin : ext_sync2;
	wire ext_rise   = ext_level && !ext_prev;
	// Internal clock stops in sleep; only the unsynchronised external path keeps counting.
	wire int_event  = !cpu_sleep;
	wire ext_event  = ext_rise && (external_sync_bypass || !cpu_sleep);
	wire raw_event  = clock_source_select ? ext_event : int_event;
	wire count_event = run_control && raw_event;
	wire tick;

	tsx_prescaler u_prescaler (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ratio    (prescale_select),
		.clear    (special_event_trigger),
		.event_in (count_event),
		.tick     (tick)
	);

	// ==========================================================
	// Bus decode
	wire wr_fire   = aw_held && w_held && !s_axi_bvalid;
	wire rd_fire   = s_axi_arvalid && s_axi_arready;
	wire wr_ctrl   = wr_fire && (aw_addr == TSX_ADDR_CONTROL)  && w_strb[0];
	wire wr_lo     = wr_fire && (aw_addr == TSX_ADDR_COUNT_LO) && w_strb[0];
	wire wr_hi     = wr_fire && (aw_addr == TSX_ADDR_COUNT_HI) && w_strb[0];
	wire wr_flag   = wr_fire && (aw_addr == TSX_ADDR_IRQ_FLAG) && w_strb[0];
	wire wr_en     = wr_fire && (aw_addr == TSX_ADDR_IRQ_EN)   && w_strb[0];
	wire wr_dir    = wr_fire && (aw_addr == TSX_ADDR_PIN_CTRL) && w_strb[0];
	wire wr_known  = (aw_addr == TSX_ADDR_CONTROL)  || (aw_addr == TSX_ADDR_COUNT_LO) ||
	                 (aw_addr == TSX_ADDR_COUNT_HI) || (aw_addr == TSX_ADDR_IRQ_FLAG) ||
	                 (aw_addr == TSX_ADDR_IRQ_EN)   || (aw_addr == TSX_ADDR_PIN_CTRL);
	// A trigger or byte write in the same cycle replaces the increment, so no wrap happens
	wire wrap      = tick && (count == TSX_COUNT_MAX) && !special_event_trigger && !wr_lo && !wr_hi;

	// Next count: trigger clear beats a write, which beats an increment
	wire [15:0] next_count = special_event_trigger ? TSX_RST_COUNT :
	                         wr_lo ? {count[15:8], w_data[7:0]} :
	                         wr_hi ? {w_data[7:0], count[7:0]} :
	                         tick  ? count + 16'h0001 : count;

	// Flag set wins over a write-one clear in the same cycle
	wire next_overflow_flag = wrap || (overflow_flag && !(wr_flag && w_data[TSX_BIT_FLAG]));

	// Pins read as zero while the oscillator owns them
	wire [1:0] pin_levels = low_power_osc_enable ? 2'b00 : {osc_input_pin, osc_output_pin};
	wire [1:0] next_dir   = wr_dir ? w_data[TSX_BIT_DIR_LO +: 2] : port_direction_bits;
	// Pin enables and inverter switch on the same edge, so no pin is driven while it runs
	wire       next_osc_en = wr_ctrl ? w_data[TSX_BIT_OSC_EN] : low_power_osc_enable;

	// Read mux
	wire [31:0] next_rdata =
		(s_axi_araddr == TSX_ADDR_CONTROL)  ? {26'h0, timer_control} :
		(s_axi_araddr == TSX_ADDR_COUNT_LO) ? {24'h0, count[7:0]} :
		(s_axi_araddr == TSX_ADDR_COUNT_HI) ? {24'h0, count[15:8]} :
		(s_axi_araddr == TSX_ADDR_IRQ_FLAG) ? {31'h0, overflow_flag} :
		(s_axi_araddr == TSX_ADDR_IRQ_EN)   ? {31'h0, overflow_irq_enable} :
		(s_axi_araddr == TSX_ADDR_PIN_CTRL) ? {24'h0, port_direction_bits, 6'h00} :
		(s_axi_araddr == TSX_ADDR_PIN_READ) ? {24'h0, pin_levels, 6'h00} : 32'h0;
	wire rd_known  = (s_axi_araddr == TSX_ADDR_CONTROL)  || (s_axi_araddr == TSX_ADDR_COUNT_LO) ||
	                 (s_axi_araddr == TSX_ADDR_COUNT_HI) || (s_axi_araddr == TSX_ADDR_IRQ_FLAG) ||
	                 (s_axi_araddr == TSX_ADDR_IRQ_EN)   || (s_axi_araddr == TSX_ADDR_PIN_CTRL) ||
	                 (s_axi_araddr == TSX_ADDR_PIN_READ);

	// ==========================================================
	// External pin edge history
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_sync1 <= 1'b0;
			ext_sync2 <= 1'b0;
			ext_prev  <= 1'b0;
		end else begin
			ext_sync1 <= external_clock_pin;
			ext_sync2 <= ext_sync1;
			ext_prev  <= ext_level;
		end
	end

	// ==========================================================
	// Timer registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_control       <= TSX_RST_CONTROL;
			count               <= TSX_RST_COUNT;
			overflow_flag       <= 1'b0;
			overflow_irq_enable <= 1'b0;
			port_direction_bits <= TSX_RST_DIR;
		end else begin
			if (wr_ctrl) begin
				timer_control <= w_data[5:0];
			end
			count               <= next_count;
			overflow_flag       <= next_overflow_flag;
			overflow_irq_enable <= wr_en ? w_data[0] : overflow_irq_enable;
			port_direction_bits <= next_dir;
		end
	end

	// ==========================================================
	// Pin, interrupt and wake outputs
	// Direction bits are kept but overridden while the oscillator is on.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_output_pin_oe_n <= 1'b1;
			osc_input_pin_oe_n  <= 1'b1;
			osc_inverter_on     <= 1'b0;
			irq                 <= 1'b0;
			wake                <= 1'b0;
		end else begin
			osc_output_pin_oe_n <= next_dir[0] || next_osc_en;
			osc_input_pin_oe_n  <= next_dir[1] || next_osc_en;
			osc_inverter_on     <= next_osc_en;
			irq                 <= next_overflow_flag && overflow_irq_enable;
			wake                <= next_overflow_flag && overflow_irq_enable && cpu_sleep;
		end
	end

	// ==========================================================
	// AXI4-Lite write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= TSX_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? TSX_RESP_OKAY : TSX_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read channel: one outstanding read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= TSX_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= rd_known ? TSX_RESP_OKAY : TSX_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : tsx_timer
`default_nettype wire
